// ---- afpi_asserts.sv ----
`timescale 1ns/1ps
module afpi_asserts (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire afpi_pkg::afpi_rate_t i_rate,
	input wire logic i_rx_valid,
	input wire logic o_rx_valid,
	input wire logic i_rx_take,
	input wire afpi_pkg::afpi_rx_word_t o_rx,
	input wire logic i_tx_sync_rfp,
	input wire logic [3:0] i_tx_mask,
	input wire logic [6:0] o_tx_seq,
	input wire logic [7:0] o_tx_x,
	input wire logic o_tx_rfp,
	input wire logic [3:0] o_tx_err
);
	import afpi_pkg::*;
	logic [1:0] up;
	logic [6:0] smax;
	assign smax = afpi_seq_max(i_rate);
	// Keeps past-value checks away from values held during reset
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			up <= 2'h0;
		else if (up != 2'h3)
			up <= up + 2'h1;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	seq_step_a: assert property (up == 2'h3 && !$rose(i_tx_sync_rfp) &&
		$stable(i_rate) && o_tx_seq < smax |=> o_tx_seq == $past(o_tx_seq) + 7'h01)
		else $error("seq step");
	seq_wrap_a: assert property (up == 2'h3 && !$rose(i_tx_sync_rfp) &&
		$stable(i_rate) && o_tx_seq == smax |=>
		o_tx_seq == 7'h00 && o_tx_x == $past(o_tx_x) + 8'h01) else $error("wrap");
	sync_restart_a: assert property (up == 2'h3 && $rose(i_tx_sync_rfp) |=>
		o_tx_seq == 7'h00 && o_tx_x == 8'h00 && o_tx_rfp) else $error("sync");
	rfp_pulse_a: assert property (o_tx_rfp |-> o_tx_seq == 7'h00 &&
		o_tx_x == 8'h00 ##1 !o_tx_rfp) else $error("rfp");
	err_map_a: assert property (up == 2'h3 && $stable(i_rate) ##1
		$stable(i_rate) |-> o_tx_err ==
		(afpi_ctrl_map($past(o_tx_seq, 2), smax) & $past(i_tx_mask)))
		else $error("err");
	rx_hold_a: assert property (o_rx_valid && !i_rx_take |=>
		o_rx_valid && $stable(o_rx)) else $error("hold");
	rx_ctrl_a: assert property (o_rx_valid |->
		o_rx.ctrl == afpi_ctrl_map(o_rx.seq, smax)) else $error("ctrl");
	rx_range_a: assert property (o_rx_valid |-> o_rx.seq <= smax &&
		o_rx.z <= AFPI_Z_MAX) else $error("range");
	hf_start_a: assert property (o_rx_valid && o_rx.hfp |->
		o_rx.seq == 7'h00 && o_rx.x == 8'h00) else $error("hfp");
	rx_show_a: assert property (!o_rx_valid && i_rx_valid |=> o_rx_valid)
		else $error("show");
	cover property ($rose(i_tx_sync_rfp));
	cover property (o_tx_seq == smax);
	cover property (o_rx_valid && !i_rx_take && i_rx_valid);
endmodule // afpi_asserts

// ---- afpi_fifo.sv ----
`timescale 1ns/1ps
module afpi_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = i_valid && o_ready;
	wire pop = o_valid && i_ready;

	assign o_ready = count != (AW+1)'(DEPTH);
	assign o_valid = count != '0;
	assign o_data = mem[rd_ptr];

	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // afpi_fifo

// ---- afpi_pkg.sv ----
package afpi_pkg;

	// Line rate selected by the link configuration
	typedef enum logic [3:0] {
		AFPI_RATE_0614,
		AFPI_RATE_1228,
		AFPI_RATE_2457,
		AFPI_RATE_3072,
		AFPI_RATE_4915,
		AFPI_RATE_6144,
		AFPI_RATE_8110,
		AFPI_RATE_9830,
		AFPI_RATE_10137
	} afpi_rate_t;

	// Last word index of a basic frame per line rate
	localparam logic [6:0] AFPI_SEQ_MAX_0614 = 7'h03;
	localparam logic [6:0] AFPI_SEQ_MAX_1228 = 7'h07;
	localparam logic [6:0] AFPI_SEQ_MAX_2457 = 7'h0f;
	localparam logic [6:0] AFPI_SEQ_MAX_3072 = 7'h13;
	localparam logic [6:0] AFPI_SEQ_MAX_4915 = 7'h1f;
	localparam logic [6:0] AFPI_SEQ_MAX_6144 = 7'h27;
	localparam logic [6:0] AFPI_SEQ_MAX_8110 = 7'h3f;
	localparam logic [6:0] AFPI_SEQ_MAX_9830 = 7'h3f;
	localparam logic [6:0] AFPI_SEQ_MAX_10137 = 7'h4f;

	localparam logic [7:0] AFPI_X_MAX = 8'hff;
	localparam logic [7:0] AFPI_Z_MAX = 8'h95;

	// Values after reset
	localparam logic [6:0] AFPI_SEQ_RST = 7'h00;
	localparam logic [7:0] AFPI_X_RST = 8'h00;
	localparam logic [7:0] AFPI_Z_RST = 8'h00;
	localparam logic [3:0] AFPI_ERR_RST = 4'h0;

	// Cycles from a transmit word index to its data word
	localparam int AFPI_WR_LAT = 1;
	localparam int AFPI_FIFO_DEPTH = 4;

	typedef struct packed {
		logic [31:0] data;
		logic [3:0] ctrl;
		logic [7:0] x;
		logic [6:0] seq;
		logic [7:0] z;
		logic hfp;
	} afpi_rx_word_t;

	localparam int AFPI_RX_W = $bits(afpi_rx_word_t);

	function automatic logic [6:0] afpi_seq_max(input afpi_rate_t r);
		case (r)
			AFPI_RATE_0614: afpi_seq_max = AFPI_SEQ_MAX_0614;
			AFPI_RATE_1228: afpi_seq_max = AFPI_SEQ_MAX_1228;
			AFPI_RATE_2457: afpi_seq_max = AFPI_SEQ_MAX_2457;
			AFPI_RATE_3072: afpi_seq_max = AFPI_SEQ_MAX_3072;
			AFPI_RATE_4915: afpi_seq_max = AFPI_SEQ_MAX_4915;
			AFPI_RATE_6144: afpi_seq_max = AFPI_SEQ_MAX_6144;
			AFPI_RATE_8110: afpi_seq_max = AFPI_SEQ_MAX_8110;
			AFPI_RATE_9830: afpi_seq_max = AFPI_SEQ_MAX_9830;
			AFPI_RATE_10137: afpi_seq_max = AFPI_SEQ_MAX_10137;
			default: afpi_seq_max = AFPI_SEQ_MAX_0614;
		endcase
	endfunction

	// Control word fills the first (words per frame / 4) bytes of a frame
	function automatic logic [3:0] afpi_ctrl_map(input logic [6:0] seq,
			input logic [6:0] smax);
		logic [8:0] nbytes;
		logic [8:0] pos;
		nbytes = 9'({2'b00, smax} + 9'h001) >> 2;
		for (int lane = 0; lane < 4; lane++) begin
			pos = {seq, 2'b00} + 9'(3 - lane);
			afpi_ctrl_map[lane] = pos < nbytes;
		end
	endfunction

endpackage

// ---- afpi_tb_top.sv ----
`timescale 1ns/1ps
module afpi_tb_top;
	import afpi_pkg::*;
	logic i_clk, i_rst_b, i_rx_valid, o_rx_ready, o_rx_valid, i_rx_take;
	logic i_tx_sync_rfp, o_tx_rfp, stall;
	afpi_rate_t i_rate;
	afpi_rx_word_t o_rx;
	logic [31:0] i_rx_word;
	logic [3:0] i_tx_mask, o_tx_err, eerr;
	logic [6:0] o_tx_seq;
	logic [7:0] o_tx_x;
	int n_mismatch, checks, npop, m, pseq;
	int smax [9] = '{3, 7, 15, 19, 31, 39, 63, 63, 79};
	afpi_top dut (.*);
	afpi_user u_user (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_stall(stall),
		.i_valid(o_rx_valid), .o_take(i_rx_take), .o_mask(i_tx_mask));
	task automatic chk(input string n, input logic [31:0] s, e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		if (n_mismatch == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [3:0] ectl(int s, int mx);
		for (int l = 0; l < 4; l++)
			ectl[l] = (4 * s + 3 - l) < (mx + 1) / 4;
	endfunction
	initial begin
		i_clk = 0;
		forever #10 i_clk = ~i_clk;
	end
	initial begin
		#100000;
		n_mismatch++;
		stop_test;
	end
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			npop = 0;
			i_rx_word <= 32'h0;
		end
		if (i_rst_b && o_rx_valid && i_rx_take) begin
			chk("data", o_rx.data, npop);
			chk("rseq", o_rx.seq, npop % (m + 1));
			chk("rx", o_rx.x, npop / (m + 1));
			chk("ctrl", o_rx.ctrl, ectl(npop % (m + 1), m));
			chk("hfp", o_rx.hfp, npop == 0);
			npop++;
		end
		if (i_rst_b && i_rx_valid && o_rx_ready)
			i_rx_word <= i_rx_word + 1;
	end
	initial begin
		i_rst_b = 0;
		i_rate = AFPI_RATE_0614;
		i_rx_valid = 0;
		i_tx_sync_rfp = 0;
		stall = 1;
		repeat (4) @(posedge i_clk);
		for (int r = 0; r < 9; r++) begin
			i_rst_b <= 0;
			i_rate <= afpi_rate_t'(r);
			m = smax[r];
			@(posedge i_clk);
			i_rst_b <= 1;
			repeat (3) @(posedge i_clk);
			i_tx_sync_rfp <= 1;
			i_rx_valid <= 1;
			@(posedge i_clk);
			i_tx_sync_rfp <= 0;
			for (int i = 0; i < m + 3; i++) begin
				#1;
				chk("seq", o_tx_seq, i % (m + 1));
				chk("x", o_tx_x, i / (m + 1));
				chk("rfp", o_tx_rfp, i == 0);
				if (i >= 2)
					chk("err", o_tx_err, eerr);
				eerr = ectl(pseq, m) & i_tx_mask;
				pseq = i % (m + 1);
				@(posedge i_clk);
			end
			#1;
			chk("full", o_rx_ready, 1'b0);
			@(posedge i_clk);
			stall <= 0;
			repeat (m + 8) @(posedge i_clk);
			i_rx_valid <= 0;
			repeat (8) @(posedge i_clk);
			#1;
			chk("empty", o_rx_valid, 1'b0);
			@(posedge i_clk);
			stall <= 1;
		end
		// Final reset after the rate sweep, then sync held high
		i_rst_b <= 0;
		@(posedge i_clk);
		#1;
		chk("rst rfp", o_tx_rfp, 1'b1);
		chk("rst err", o_tx_err, 4'h0);
		chk("rst rdy", o_rx_ready, 1'b1);
		@(posedge i_clk);
		i_rst_b <= 1;
		repeat (3) @(posedge i_clk);
		i_tx_sync_rfp <= 1;
		repeat (4) @(posedge i_clk);
		#1;
		chk("held", o_tx_seq, 7'h03);
		stop_test;
	end
endmodule // afpi_tb_top
bind afpi_top afpi_asserts chk_i (.*);

// ---- afpi_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Receive basic frame index is 8 bits and counts 0 to 255.
// RULE2: Receive word index is 7 bits, one 32-bit word of the frame.
// RULE3: At the three lowest rates the word index wraps after 3, 7, 15.
// RULE4: At 3.072, 4.9152, 6.144 Gbps it wraps after 19, 31, 39.
// RULE5: At 8.11008 and 9.8304 it wraps after 63; at 10.1376 after 79.
// RULE6: Received words carry the earliest line byte in bits 31 to 24.
// RULE7: Four control flags mark byte lanes holding control word bytes.
// RULE8: Rising edge of transmit frame sync restarts transmit framing.
// RULE9: Transmit error flags one cycle after unmasked bytes hit control.
// RULE10: One transmit pulse marks the start of every radio frame.
// RULE11: All interface signals live on the single link output clock.
// RULE12: Receive hyperframe number runs 0 to 149.
// RULE13: Receive hyperframe start pulse marks its first word.
// RULE14: User places transmit data one cycle after its word index.
// RULE15: Word index steps per word, carrying into frame then hyperframe.
module afpi_top (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire afpi_pkg::afpi_rate_t i_rate,
	input wire logic i_rx_valid,
	output logic o_rx_ready,
	input wire logic [31:0] i_rx_word,
	output logic o_rx_valid,
	input wire logic i_rx_take,
	output afpi_pkg::afpi_rx_word_t o_rx,
	input wire logic i_tx_sync_rfp,
	input wire logic [3:0] i_tx_mask,
	output logic [6:0] o_tx_seq,
	output logic [7:0] o_tx_x,
	output logic o_tx_rfp,
	output logic [3:0] o_tx_err
);
	import afpi_pkg::*;

	// Every port is on i_clk, so no synchronisers are needed
	// (RULE11)

	// Rate decode; unused codes fall back to the slowest rate
	wire rate_1228 = i_rate == AFPI_RATE_1228;
	wire rate_2457 = i_rate == AFPI_RATE_2457;
	wire rate_3072 = i_rate == AFPI_RATE_3072;
	wire rate_4915 = i_rate == AFPI_RATE_4915;
	wire rate_6144 = i_rate == AFPI_RATE_6144;
	wire rate_8110 = i_rate == AFPI_RATE_8110;
	wire rate_9830 = i_rate == AFPI_RATE_9830;
	wire rate_10137 = i_rate == AFPI_RATE_10137;

	// Last word index of a basic frame at the selected rate
	wire [6:0] seq_max =
		rate_1228 ? AFPI_SEQ_MAX_1228 :
		rate_2457 ? AFPI_SEQ_MAX_2457 :
		rate_3072 ? AFPI_SEQ_MAX_3072 :
		rate_4915 ? AFPI_SEQ_MAX_4915 :
		rate_6144 ? AFPI_SEQ_MAX_6144 :
		rate_8110 ? AFPI_SEQ_MAX_8110 :
		rate_9830 ? AFPI_SEQ_MAX_9830 :
		rate_10137 ? AFPI_SEQ_MAX_10137 :
		AFPI_SEQ_MAX_0614; // RULE3 RULE4 RULE5

	// The control word takes one byte per four words of the frame
	wire [7:0] words_per_bf = {1'b0, seq_max} + 8'h01;
	wire [8:0] ctrl_bytes = {3'b000, words_per_bf[7:2]};

	// Receive position counters
	logic [6:0] rx_seq;
	logic [7:0] rx_x;
	logic [7:0] rx_z;
	wire rx_adv = i_rx_valid && o_rx_ready;
	wire rx_seq_wrap = rx_seq >= seq_max; // RULE3 RULE4 RULE5
	wire rx_x_wrap = rx_x == AFPI_X_MAX; // RULE1
	wire rx_z_wrap = rx_z == AFPI_Z_MAX; // RULE12
	wire [6:0] next_rx_seq = rx_seq_wrap ? AFPI_SEQ_RST : rx_seq + 7'h01;
	wire [7:0] next_rx_x = rx_x_wrap ? AFPI_X_RST : rx_x + 8'h01;
	wire [7:0] next_rx_z = rx_z_wrap ? AFPI_Z_RST : rx_z + 8'h01;

	// Counters move only on accepted words; idle cycles hold position
	wire rx_x_step = rx_adv && rx_seq_wrap;
	wire rx_z_step = rx_x_step && rx_x_wrap;
	wire [3:0] rx_ctrl;

	// Position is carried with the word, so the user sees matching tags
	// even when the fifo is holding words back
	afpi_rx_word_t rx_in;
	assign rx_in.data = i_rx_word; // RULE6
	assign rx_in.ctrl = rx_ctrl; // RULE7
	assign rx_in.x = rx_x; // RULE1
	assign rx_in.seq = rx_seq; // RULE2
	assign rx_in.z = rx_z; // RULE12
	assign rx_in.hfp = (rx_seq == AFPI_SEQ_RST) && (rx_x == AFPI_X_RST); // RULE13

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_seq <= AFPI_SEQ_RST;
		end else if (rx_adv) begin
			rx_seq <= next_rx_seq; // RULE15
		end
	end

	// Frame index moves only when the word index wraps
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_x <= AFPI_X_RST;
		end else if (rx_x_step) begin
			rx_x <= next_rx_x; // RULE15
		end
	end

	// Hyperframe number moves when the frame index wraps
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_z <= AFPI_Z_RST;
		end else if (rx_z_step) begin
			rx_z <= next_rx_z; // RULE15
		end
	end

	// Stalls the deframer when the user stops taking words
	afpi_fifo #(
		.W(AFPI_RX_W),
		.DEPTH(AFPI_FIFO_DEPTH)
	) u_rx_fifo (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_valid(i_rx_valid),
		.o_ready(o_rx_ready),
		.i_data(rx_in),
		.o_valid(o_rx_valid),
		.i_ready(i_rx_take),
		.o_data(o_rx)
	);

	// Transmit framing
	logic sync_prev;
	logic [6:0] tx_seq;
	logic [7:0] tx_x;
	logic [7:0] tx_z;
	wire sync_rise = i_tx_sync_rfp && !sync_prev; // RULE8
	wire tx_seq_wrap = tx_seq >= seq_max;
	wire tx_x_wrap = tx_x == AFPI_X_MAX;
	wire tx_z_wrap = tx_z == AFPI_Z_MAX;
	wire [6:0] next_tx_seq = tx_seq_wrap ? AFPI_SEQ_RST : tx_seq + 7'h01;
	wire [7:0] next_tx_x = tx_seq_wrap ?
		(tx_x_wrap ? AFPI_X_RST : tx_x + 8'h01) : tx_x;
	wire [7:0] next_tx_z = (tx_seq_wrap && tx_x_wrap) ?
		(tx_z_wrap ? AFPI_Z_RST : tx_z + 8'h01) : tx_z;
	wire next_tx_start = (next_tx_seq == AFPI_SEQ_RST) &&
		(next_tx_x == AFPI_X_RST) && (next_tx_z == AFPI_Z_RST);

	// Control bytes at the index shown, waiting for their data word
	logic [3:0] tx_ctrl_pend;
	wire [3:0] tx_ctrl_now;

	// Lane 3 holds the earliest byte, so it sits lowest in the frame
	for (genvar lane = 0; lane < 4; lane++) begin : g_lane
		wire [8:0] rx_pos = {rx_seq, 2'b00} + 9'(3 - lane);
		wire [8:0] tx_pos = {tx_seq, 2'b00} + 9'(3 - lane);
		assign rx_ctrl[lane] = rx_pos < ctrl_bytes; // RULE7
		assign tx_ctrl_now[lane] = tx_pos < ctrl_bytes; // RULE9
	end

	assign o_tx_seq = tx_seq;
	assign o_tx_x = tx_x;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync_prev <= 1'b0;
		end else begin
			sync_prev <= i_tx_sync_rfp;
		end
	end

	// A sync edge wins over the free-running count
	wire [6:0] next_tx_seq_ld = sync_rise ? AFPI_SEQ_RST : next_tx_seq;
	wire [7:0] next_tx_x_ld = sync_rise ? AFPI_X_RST : next_tx_x;
	wire [7:0] next_tx_z_ld = sync_rise ? AFPI_Z_RST : next_tx_z;
	wire next_tx_rfp = sync_rise || next_tx_start;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_seq <= AFPI_SEQ_RST;
		end else begin
			tx_seq <= next_tx_seq_ld; // RULE8 RULE15
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_x <= AFPI_X_RST;
		end else begin
			tx_x <= next_tx_x_ld; // RULE8 RULE15
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_z <= AFPI_Z_RST;
		end else begin
			tx_z <= next_tx_z_ld; // RULE8 RULE15
		end
	end

	// Frame zero starts at reset, so the pulse shows there too
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_tx_rfp <= 1'b1;
		end else begin
			o_tx_rfp <= next_tx_rfp; // RULE10
		end
	end

	// Data for index n arrives one cycle later; its error one after that
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_ctrl_pend <= AFPI_ERR_RST;
			o_tx_err <= AFPI_ERR_RST;
		end else begin
			tx_ctrl_pend <= tx_ctrl_now; // RULE14
			o_tx_err <= tx_ctrl_pend & i_tx_mask; // RULE9
		end
	end
endmodule // afpi_top

// ---- afpi_user.sv ----
`timescale 1ns/1ps
module afpi_user (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_stall,
	input wire logic i_valid,
	output logic o_take,
	output logic [3:0] o_mask
);
	assign o_take = i_valid && !i_stall;
	// Mask keeps changing so every lane meets a control slot
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b)
			o_mask <= 4'h5;
		else
			o_mask <= {o_mask[2:0], ~o_mask[3]};
	end
endmodule // afpi_user
